// File: tcc_cc_ctrl.sv
// tcc_cc_ctrl: role, attach, orientation and current level control of a type-c port
//
// Overview of operation
// R01 - Strap high selects source-only, low sink-only, floating dual-role.
// R02 - Strap is sampled once after reset; later changes ignored until reset.
// R03 - With floating strap, role field 2'b10 selects source-only.
// R04 - Source-only role presents Rp on both CC lines, starting at default level.
// R05 - As source, advertised level follows pin or register; Rp setting retuned.
// R06 - Source with Rd seen in Attached.SRC drives attach flag low.
// R07 - On sink attach, VCONN goes to unused CC line only if Ra there.
// R08 - Host sets termination-off, writes role field 2'b10, then clears it.
// R09 - Attach flag stays high until VBUS reaches vSafe0V, then goes low.
// R10 - Sink-only role presents Rd on both CC lines and watches CC levels.
// R11 - As sink, CC is debounced and VBUS required before attach completes.
// R12 - In Attached.SNK source level reported on level pins or status field.
// R13 - Dual-role alternates Rp and Rd on both lines until attached.
// R14 - Try.SRC only in register mode; pin mode behaves as standard dual-role.
// R15 - Preference 2'b11 enables Try.SRC, aiming to end attached as source.
// R16 - Flip pin released high for CC1, driven low for CC2.
// R17 - Orientation steers the superspeed mux and is readable in status.
// R18 - Pin mode level from level pin; register mode from advert field.
// R19 - Floating bus select gives pin mode; driven gives register mode, bit 6.
// R20 - Level pins: A high default; A low B high medium; both low high.
// R21 - Termination-off removes terminations; role field applied on its clear.
`timescale 1ns/100ps

module tcc_cc_ctrl
  import tcc_pkg::*;
#(
  parameter int CC_DEBOUNCE_CYCLES = tcc_pkg::CC_DEBOUNCE_CYC, // attach debounce
  parameter int DRP_HALF_CYCLES    = tcc_pkg::DRP_HALF_CYC     // each toggle half
) (
  input  wire logic       core_clk,         // 125 MHz core clock
  input  wire logic       resetn,           // async reset, active low
  input  wire logic       roleStrapHi,      // role strap pulled high
  input  wire logic       roleStrapLo,      // role strap pulled low
  input  wire logic       busSelHi,         // bus select pulled high
  input  wire logic       busSelLo,         // bus select pulled low
  input  wire logic [1:0] advertLevelPin,   // requested level in pin mode
  input  wire logic       cc1Rd,            // Rd seen on cc1
  input  wire logic       cc2Rd,            // Rd seen on cc2
  input  wire logic       cc1Ra,            // Ra seen on cc1
  input  wire logic       cc2Ra,            // Ra seen on cc2
  input  wire logic [1:0] cc1SrcLevel,      // source level seen on cc1
  input  wire logic [1:0] cc2SrcLevel,      // source level seen on cc2
  input  wire logic       vbusDetected,     // vbus present
  input  wire logic       vbusSafe0v,       // vbus at vSafe0V
  input  wire logic       regWrEn,          // register write strobe
  input  wire logic       regRdEn,          // register read strobe
  input  wire logic [7:0] regAddr,          // register offset
  input  wire logic [7:0] regWrData,        // write data
  output logic      [7:0] regRdData,        // read data, one cycle later
  output logic            ccRpEn,           // Rp on both cc lines
  output logic            ccRdEn,           // Rd on both cc lines
  output logic      [1:0] rpLevel,          // Rp current setting
  output logic            vconnCc1En,       // vconn switched to cc1
  output logic            vconnCc2En,       // vconn switched to cc2
  output logic            attachFlagOut,    // open-drain data, always low
  output logic            attachFlagOe,     // attach flag pulled low
  output logic            flipIndicatorOut, // open-drain data, always low
  output logic            flipIndicatorOe,  // flip pin pulled low (cc2)
  output logic            muxSelCc2,        // mux on rx2/tx2 pair
  output logic            levelOutAOut,     // open-drain data, always low
  output logic            levelOutAOe,      // level_out_a pulled low
  output logic            levelOutBOut,     // open-drain data, always low
  output logic            levelOutBOe,      // level_out_b pulled low
  output logic            i2cMode,          // register mode selected
  output logic            i2cAddrBit6       // address bit 6 in register mode
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic isSrcState(input tcc_state_e s);
    return (s == ST_UNATT_SRC) || (s == ST_ATTWAIT_SRC) || (s == ST_ATT_SRC)
        || (s == ST_TRY_SRC);
  endfunction

  function automatic tcc_role_e decodeStrap(input logic hi, input logic lo);
    if (hi) return ROLE_SRC_ONLY;
    if (lo) return ROLE_SNK_ONLY;
    return ROLE_DUAL;
  endfunction

  tcc_state_e             state;
  tcc_state_e             next_state;
  tcc_role_e              strapRole;
  tcc_role_e              role;
  logic                   strapDone;
  logic                   termOff;
  logic [1:0]             rolePref;
  logic [1:0]             roleSel;
  logic [1:0]             appliedRoleSel;
  logic [1:0]             advertLevelField;
  logic [1:0]             sensedLevel;
  logic                   orientCc2;
  logic [TIMER_W-1:0]     timer;
  logic                   timerDone;
  logic                   rdSeen;
  logic                   srcSeen;
  logic                   trySrcOk;
  tcc_state_e             unattHome;

  // ----------------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------------
  // straps caught by a clock edge, never by the async reset itself
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strapDone   <= 1'b0;
      strapRole   <= ROLE_DUAL;
      i2cMode     <= 1'b0;
      i2cAddrBit6 <= 1'b0;
    end else if (!strapDone) begin
      strapDone   <= 1'b1;                               // R02
      strapRole   <= decodeStrap(roleStrapHi, roleStrapLo); // R01
      i2cMode     <= busSelHi | busSelLo;                // R19
      i2cAddrBit6 <= busSelHi;                           // R19
    end
  end

  // floating strap may be overridden by the applied role field
  always_comb begin
    role = strapRole;
    if (strapRole == ROLE_DUAL && appliedRoleSel == ROLE_SEL_SRC) begin
      role = ROLE_SRC_ONLY;                              // R03
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // role field only takes effect while terminations are on, so a host
  // following the off / write / on order never sees a half-applied role
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      termOff          <= PORT_ROLE_CTRL_RST[TERM_OFF_BIT];
      rolePref         <= PORT_ROLE_CTRL_RST[PREF_LSB +: 2];
      roleSel          <= PORT_ROLE_CTRL_RST[ROLE_SEL_LSB +: 2];
      appliedRoleSel   <= ROLE_SEL_DEFAULT;
      advertLevelField <= LVL_DEFAULT;
    end else begin
      if (regWrEn && regAddr == REG_PORT_ROLE_CTRL) begin
        termOff  <= regWrData[TERM_OFF_BIT];             // R08
        rolePref <= regWrData[PREF_LSB +: 2];
        roleSel  <= regWrData[ROLE_SEL_LSB +: 2];        // R08
      end
      if (regWrEn && regAddr == REG_ADVERT_CTRL && regWrData[1:0] != LVL_NONE) begin
        advertLevelField <= regWrData[1:0];              // R05
      end
      if (!termOff) begin
        appliedRoleSel <= roleSel;                       // R21
      end
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        REG_PORT_ROLE_CTRL: regRdData <= {2'b00, roleSel, 1'b0, rolePref, termOff};
        REG_ADVERT_CTRL:    regRdData <= {6'h00, advertLevelField};
        REG_PORT_STATUS:    regRdData <= {2'b00, sensedLevel, 1'b0, orientCc2, // R17
                                          state == ST_ATT_SRC,
                                          state == ST_ATT_SNK || state == ST_ATT_SRC};
        default:            regRdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // attach state machine
  // ----------------------------------------------------------------------
  assign rdSeen    = cc1Rd | cc2Rd;
  assign srcSeen   = (cc1SrcLevel != LVL_NONE) | (cc2SrcLevel != LVL_NONE);
  assign trySrcOk  = i2cMode && role == ROLE_DUAL && rolePref == PREF_TRY_SRC; // R14 R15
  assign unattHome = (role == ROLE_SNK_ONLY || role == ROLE_DUAL) ? ST_UNATT_SNK
                                                                   : ST_UNATT_SRC;
  // unattached states time the toggle, all others the debounce
  assign timerDone = (state == ST_UNATT_SRC || state == ST_UNATT_SNK)
                   ? (timer >= TIMER_W'(DRP_HALF_CYCLES - 1))
                   : (timer >= TIMER_W'(CC_DEBOUNCE_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_DISABLED: if (strapDone && !termOff && appliedRoleSel == roleSel) next_state = unattHome;
      ST_UNATT_SRC: begin
        if (rdSeen) next_state = ST_ATTWAIT_SRC;
        else if (role == ROLE_DUAL && timerDone) next_state = ST_UNATT_SNK; // R13
      end
      ST_ATTWAIT_SRC: begin
        if (!rdSeen) next_state = unattHome;
        else if (timerDone) next_state = ST_ATT_SRC;
      end
      ST_ATT_SRC:     if (!rdSeen) next_state = unattHome;
      ST_UNATT_SNK: begin
        if (role == ROLE_SRC_ONLY) next_state = ST_UNATT_SRC;
        else if (srcSeen) next_state = ST_ATTWAIT_SNK;
        else if (role == ROLE_DUAL && timerDone) next_state = ST_UNATT_SRC; // R13
      end
      ST_ATTWAIT_SNK: begin
        if (!srcSeen) next_state = unattHome;
        else if (timerDone && vbusDetected) begin        // R11
          next_state = trySrcOk ? ST_TRY_SRC : ST_ATT_SNK; // R15
        end
      end
      ST_ATT_SNK:     if (!vbusDetected) next_state = unattHome;
      ST_TRY_SRC: begin
        // partner that stays a sink wins us the source role
        if (rdSeen && timerDone) next_state = ST_ATT_SRC;              // R15
        else if (timerDone) next_state = vbusDetected ? ST_ATT_SNK : unattHome;
      end
    endcase
    if (termOff || !strapDone) next_state = ST_DISABLED; // R21
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) state <= ST_DISABLED;
    else         state <= next_state;
  end

  // one timer, restarted on every state change
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)                  timer <= '0;
    else if (next_state != state) timer <= '0;
    else if (!timerDone)          timer <= timer + TIMER_W'(1);
  end

  // ----------------------------------------------------------------------
  // terminations and advertised level
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ccRpEn  <= 1'b0;
      ccRdEn  <= 1'b0;
      rpLevel <= LVL_DEFAULT;
    end else begin
      ccRpEn  <= state != ST_DISABLED && isSrcState(state);   // R04 R13
      ccRdEn  <= state != ST_DISABLED && !isSrcState(state);  // R10 R13
      rpLevel <= i2cMode ? advertLevelField                   // R18
                         : (advertLevelPin == LVL_NONE ? LVL_DEFAULT : advertLevelPin); // R05
    end
  end

  // ----------------------------------------------------------------------
  // orientation, mux, vconn, attach flag
  // ----------------------------------------------------------------------
  // orientation frozen at attach so a noisy unused line cannot flip the mux
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      orientCc2 <= 1'b0;
    end else if (state == ST_ATTWAIT_SRC || state == ST_TRY_SRC) begin
      orientCc2 <= cc2Rd && !cc1Rd;                            // R16
    end else if (state == ST_ATTWAIT_SNK) begin
      orientCc2 <= cc2SrcLevel != LVL_NONE && cc1SrcLevel == LVL_NONE; // R16
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      muxSelCc2        <= 1'b0;
      flipIndicatorOut <= 1'b0;
      flipIndicatorOe  <= 1'b0;
      vconnCc1En       <= 1'b0;
      vconnCc2En       <= 1'b0;
    end else begin
      muxSelCc2        <= orientCc2;                           // R17
      flipIndicatorOut <= 1'b0;
      flipIndicatorOe  <= orientCc2;                           // R16
      vconnCc1En       <= state == ST_ATT_SRC && orientCc2 && cc1Ra;  // R07
      vconnCc2En       <= state == ST_ATT_SRC && !orientCc2 && cc2Ra; // R07
    end
  end

  // low only after vbus drained once; stays low for the whole attach
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      attachFlagOut <= 1'b0;
      attachFlagOe  <= 1'b0;
    end else begin
      attachFlagOut <= 1'b0;
      if (state != ST_ATT_SRC) attachFlagOe <= 1'b0;
      else if (vbusSafe0v)     attachFlagOe <= 1'b1;          // R06 R09
    end
  end

  // ----------------------------------------------------------------------
  // sensed level reporting as sink
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sensedLevel  <= LVL_NONE;
      levelOutAOut <= 1'b0;
      levelOutAOe  <= 1'b0;
      levelOutBOut <= 1'b0;
      levelOutBOe  <= 1'b0;
    end else begin
      levelOutAOut <= 1'b0;
      levelOutBOut <= 1'b0;
      if (state == ST_ATT_SNK) begin
        sensedLevel <= orientCc2 ? cc2SrcLevel : cc1SrcLevel; // R12
        // pins shared with the serial bus, so only driven in pin mode
        levelOutAOe <= !i2cMode && sensedLevel >= LVL_MID;    // R20
        levelOutBOe <= !i2cMode && sensedLevel == LVL_HIGH;   // R20
      end else begin
        sensedLevel <= LVL_NONE;
        levelOutAOe <= 1'b0;
        levelOutBOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_strap_decode;
    @(posedge core_clk) disable iff (!resetn)
    $rose(strapDone) |-> strapRole == decodeStrap($past(roleStrapHi), $past(roleStrapLo));
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong"); // R01

  property p_strap_hold;
    @(posedge core_clk) disable iff (!resetn)
    strapDone |=> $stable(strapRole) && $stable(i2cMode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // R02

  property p_src_term;
    @(posedge core_clk) disable iff (!resetn)
    (role == ROLE_SRC_ONLY && state != ST_DISABLED) ##1 (state != ST_DISABLED)
      |-> ccRpEn && !ccRdEn;
  endproperty
  a_src_term: assert property (p_src_term) else $error("source lacks Rp"); // R04

  property p_attach_flag;
    @(posedge core_clk) disable iff (!resetn)
    $rose(attachFlagOe) |-> $past(state) == ST_ATT_SRC && $past(vbusSafe0v);
  endproperty
  a_attach_flag: assert property (p_attach_flag) else $error("attach flag early"); // R09

  property p_vconn;
    @(posedge core_clk) disable iff (!resetn)
    vconnCc2En |-> $past(cc2Ra) && !$past(orientCc2) && !vconnCc1En;
  endproperty
  a_vconn: assert property (p_vconn) else $error("vconn without Ra"); // R07

  property p_snk_vbus;
    @(posedge core_clk) disable iff (!resetn)
    (state == ST_ATTWAIT_SNK) ##1 (state == ST_ATT_SNK) |-> $past(vbusDetected);
  endproperty
  a_snk_vbus: assert property (p_snk_vbus) else $error("sink attach w/o vbus"); // R11

  property p_try_gpio;
    @(posedge core_clk) disable iff (!resetn)
    !i2cMode |-> state != ST_TRY_SRC;
  endproperty
  a_try_gpio: assert property (p_try_gpio) else $error("try in pin mode"); // R14

  property p_term_off;
    @(posedge core_clk) disable iff (!resetn)
    termOff |=> state == ST_DISABLED ##1 (!ccRpEn && !ccRdEn);
  endproperty
  a_term_off: assert property (p_term_off) else $error("terminations not off"); // R21

  property p_flip;
    @(posedge core_clk) disable iff (!resetn)
    ##1 (flipIndicatorOe == $past(orientCc2)) && (muxSelCc2 == flipIndicatorOe);
  endproperty
  a_flip: assert property (p_flip) else $error("flip pin mismatch"); // R16

endmodule // tcc_cc_ctrl

// File: tcc_pkg.sv
// tcc_pkg: constants and types for the type-c configuration channel controller
package tcc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_PORT_ROLE_CTRL = 8'h0A;
  localparam logic [7:0] REG_ADVERT_CTRL    = 8'h0B;
  localparam logic [7:0] REG_PORT_STATUS    = 8'h0C;
  localparam int         TERM_OFF_BIT       = 0;
  localparam int         PREF_LSB           = 1;
  localparam int         ROLE_SEL_LSB       = 4;
  localparam int         ST_ATTACHED_BIT    = 0;
  localparam int         ST_AS_SRC_BIT      = 1;
  localparam int         ST_ORIENT_BIT      = 2;
  localparam int         ST_LEVEL_LSB       = 4;
  localparam logic [7:0] PORT_ROLE_CTRL_RST = 8'h00;
  localparam logic [1:0] ROLE_SEL_DEFAULT   = 2'h0;
  localparam logic [1:0] ROLE_SEL_SRC       = 2'h2;
  localparam logic [1:0] PREF_TRY_SRC       = 2'h3;

  // ----------------------------------------------------------------------
  // current levels, shared by pins, fields and cc sensing
  // ----------------------------------------------------------------------
  localparam logic [1:0] LVL_NONE    = 2'h0;
  localparam logic [1:0] LVL_DEFAULT = 2'h1;
  localparam logic [1:0] LVL_MID     = 2'h2;
  localparam logic [1:0] LVL_HIGH    = 2'h3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int T_CC_DEBOUNCE_NS = 100_000_000;
  localparam int T_DRP_HALF_NS    = 75_000_000;
  localparam int CC_DEBOUNCE_CYC  = (T_CC_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRP_HALF_CYC     = T_DRP_HALF_NS / CLK_PERIOD_NS;
  localparam int TIMER_W          = 24;

  typedef enum logic [1:0] {
    ROLE_SRC_ONLY = 2'h0,
    ROLE_SNK_ONLY = 2'h1,
    ROLE_DUAL     = 2'h2
  } tcc_role_e;

  // gray codes along source path, then sink path
  typedef enum logic [2:0] {
    ST_UNATT_SRC   = 3'h0,
    ST_ATTWAIT_SRC = 3'h1,
    ST_ATT_SRC     = 3'h3,
    ST_UNATT_SNK   = 3'h2,
    ST_ATTWAIT_SNK = 3'h6,
    ST_ATT_SNK     = 3'h7,
    ST_TRY_SRC     = 3'h5,
    ST_DISABLED    = 3'h4
  } tcc_state_e;

endpackage

// File: tcc_partner.sv
// tcc_partner: behavioural model of the port partner on the cc lines
`timescale 1ns/100ps

module tcc_partner
  import tcc_pkg::*;
(
  input  wire logic       ccRpEn,       // our Rp present
  input  wire logic       ccRdEn,       // our Rd present
  input  wire logic       beSink,       // partner acts as sink
  input  wire logic       beSrc,        // partner acts as source
  input  wire logic       useCc2,       // partner plugged on cc2
  input  wire logic       raOther,      // active cable Ra on other line
  input  wire logic [1:0] srcLvl,       // level partner advertises
  input  wire logic       vbusOn,       // partner supplies vbus
  output logic            cc1Rd,        // Rd seen on cc1
  output logic            cc2Rd,        // Rd seen on cc2
  output logic            cc1Ra,        // Ra seen on cc1
  output logic            cc2Ra,        // Ra seen on cc2
  output logic      [1:0] cc1SrcLevel,  // level seen on cc1
  output logic      [1:0] cc2SrcLevel,  // level seen on cc2
  output logic            vbusDetected  // vbus present
);
  // ------------------------------------------------------------------
  // terminations only show when the opposite pull is present
  // ------------------------------------------------------------------
  assign cc1Rd = beSink && ccRpEn && !useCc2;
  assign cc2Rd = beSink && ccRpEn && useCc2;
  assign cc1Ra = beSink && ccRpEn && raOther && useCc2;
  assign cc2Ra = beSink && ccRpEn && raOther && !useCc2;
  // a source only raises the line while our Rd pulls it
  assign cc1SrcLevel = (beSrc && ccRdEn && !useCc2) ? srcLvl : LVL_NONE;
  assign cc2SrcLevel = (beSrc && ccRdEn && useCc2) ? srcLvl : LVL_NONE;
  assign vbusDetected = beSrc && vbusOn;
endmodule // tcc_partner

// File: testbench.sv
// testbench: self-checking bench for the cc controller
`timescale 1ns/100ps

module testbench;
  import tcc_pkg::*;
  logic core_clk = 0, resetn = 0, roleStrapHi = 0, roleStrapLo = 0;
  logic busSelHi = 0, busSelLo = 0, vbusSafe0v = 0, regWrEn = 0, regRdEn = 0;
  logic beSink = 0, beSrc = 0, useCc2 = 0, raOther = 0, vbusOn = 0;
  logic [1:0] advertLevelPin = 2'h1, srcLvl = 2'h0, lvl, rdPipe = 2'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic cc1Rd, cc2Rd, cc1Ra, cc2Ra, vbusDetected, ccRpEn, ccRdEn, vconnCc1En, vconnCc2En;
  logic [1:0] cc1SrcLevel, cc2SrcLevel, rpLevel;
  logic attachFlagOut, attachFlagOe, flipIndicatorOut, flipIndicatorOe, muxSelCc2;
  logic levelOutAOut, levelOutAOe, levelOutBOut, levelOutBOe, i2cMode, i2cAddrBit6;
  logic sawRp, sawRd;
  logic [15:0] expQ[$];
  logic [15:0] q;
  int fails = 0, cmp_count = 0, cyc = 0, i;

  // short counts keep every attach within a few dozen cycles
  tcc_cc_ctrl #(.CC_DEBOUNCE_CYCLES(8), .DRP_HALF_CYCLES(16)) u_dut (.*);
  tcc_partner u_partner (.*);

  // ------------------------------------------------------------------
  // clock, timeout and read-data scoreboard
  // ------------------------------------------------------------------
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // read data is looked at on the falling edge one and a half cycles after the read edge
  always @(posedge core_clk) rdPipe <= {rdPipe[0], regRdEn};
  always @(negedge core_clk) begin
    if (rdPipe[1] && expQ.size() > 0) begin
      q = expQ.pop_front();
      chk("regRdData", q[15:8], regRdData & q[7:0]);
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic h, l, bh, bl);
    resetn = 0;
    {roleStrapHi, roleStrapLo, busSelHi, busSelLo} = {h, l, bh, bl};
    {beSink, beSrc, raOther, vbusOn, vbusSafe0v} = 5'h0;
    repeat (4) @(negedge core_clk);
    resetn = 1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    {regWrEn, regAddr, regWrData} = {1'b1, a, d};
    @(negedge core_clk);
    regWrEn = 0;
    @(negedge core_clk);
  endtask
  // expectation noted by the driver, compared when the data shows
  task automatic rd(input logic [7:0] a, e, m);
    {regRdEn, regAddr} = {1'b1, a};
    expQ.push_back({e, m});
    @(negedge core_clk);
    regRdEn = 0;
    repeat (3) @(negedge core_clk);
  endtask

  initial begin
    void'($urandom(32'hA3CE));
    // source-only, register mode; strap moves after sampling
    do_reset(1, 0, 0, 1);
    {roleStrapHi, roleStrapLo} = 2'b01;
    repeat (4) @(negedge core_clk);
    chk("rpRd", 8'h2, {6'h0, ccRpEn, ccRdEn});
    chk("rpLevel", LVL_DEFAULT, rpLevel);
    chk("busMode", 8'h2, {6'h0, i2cMode, i2cAddrBit6});
    rd(REG_PORT_ROLE_CTRL, PORT_ROLE_CTRL_RST, 8'hFF);
    rd(8'h33, 8'h00, 8'hFF);
    lvl = 2'($urandom_range(3, 1));
    wr(REG_ADVERT_CTRL, {6'h0, lvl});
    repeat (3) @(negedge core_clk);
    chk("rpLevelSet", lvl, rpLevel);
    {beSink, useCc2, raOther} = 3'b111;
    repeat (40) @(negedge core_clk);
    chk("flagBeforeSafe", 8'h0, attachFlagOe);
    chk("rpKept", 8'h2, {6'h0, ccRpEn, ccRdEn});
    vbusSafe0v = 1;
    for (i = 0; i < 50 && attachFlagOe !== 1'b1; i++) @(negedge core_clk);
    chk("attachFlag", 8'h1, attachFlagOe);
    chk("vconn", 8'h1, {6'h0, vconnCc2En, vconnCc1En});
    chk("flipMux", 8'h3, {6'h0, flipIndicatorOe, muxSelCc2});
    chk("odData", 8'h0, {4'h0, attachFlagOut, flipIndicatorOut, levelOutAOut, levelOutBOut});
    rd(REG_PORT_STATUS, 8'h07, 8'h07);
    // sink-only, pin mode; vbus arrives late
    do_reset(0, 1, 0, 0);
    chk("rpRdSnk", 8'h1, {6'h0, ccRpEn, ccRdEn});
    chk("pinMode", 8'h0, i2cMode);
    advertLevelPin = 2'($urandom_range(3, 1));
    {beSrc, useCc2, srcLvl} = {2'b10, LVL_MID};
    repeat (40) @(negedge core_clk);
    chk("noVbus", 8'h0, levelOutAOe);
    vbusOn = 1;
    for (i = 0; i < 50 && levelOutAOe !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    chk("levelPins", 8'h2, {6'h0, levelOutAOe, levelOutBOe});
    chk("flipMuxCc1", 8'h0, {6'h0, flipIndicatorOe, muxSelCc2});
    chk("rpLevelPin", advertLevelPin, rpLevel);
    // dual role, register mode with address bit high
    do_reset(0, 0, 1, 0);
    chk("addrBit", 8'h1, i2cAddrBit6);
    {sawRp, sawRd} = 2'b00;
    for (i = 0; i < 80; i++) begin
      @(negedge core_clk);
      sawRp |= ccRpEn;
      sawRd |= ccRdEn;
    end
    chk("toggle", 8'h3, {6'h0, sawRp, sawRd});
    // try.src: partner shows as source first, then answers our Rp with Rd
    wr(REG_PORT_ROLE_CTRL, 8'h06);
    {beSrc, vbusOn} = 2'b11;
    for (i = 0; i < 60 && ccRdEn !== 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < 60 && ccRpEn !== 1'b1; i++) @(negedge core_clk);
    beSink = 1;
    repeat (20) @(negedge core_clk);
    rd(REG_PORT_STATUS, 8'h03, 8'h07);
    wr(REG_PORT_ROLE_CTRL, 8'h01);
    repeat (4) @(negedge core_clk);
    chk("termOff", 8'h0, {6'h0, ccRpEn, ccRdEn});
    wr(REG_PORT_ROLE_CTRL, 8'h21);
    repeat (4) @(negedge core_clk);
    chk("roleHeld", 8'h0, {6'h0, ccRpEn, ccRdEn});
    wr(REG_PORT_ROLE_CTRL, 8'h20);
    repeat (8) @(negedge core_clk);
    {sawRp, sawRd} = 2'b10;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      sawRp &= ccRpEn;
      sawRd |= ccRdEn;
    end
    chk("srcOnly", 8'h2, {6'h0, sawRp, sawRd});
    rd(REG_PORT_ROLE_CTRL, 8'h20, 8'hFF);
    test_done();
  end
endmodule // testbench
